/* rtl/mdsp_defs.vh */
// Operation
// - a detected high-side short ends the chopper cycle in progress
// - short counter counts up per short, down one per polarity change
// - counter at 3 shuts driver down until disable then re-enable
// - status bit 3 reads 1 while short shutdown is in force
// - status bit 1 reads 1 while shut down for overtemperature
// - status bit 0 and load pin high when load threshold is reached
// - all serial signals are sampled by the system clock only
// - serial inputs and driver enable are glitch filtered
// - extra input bits pass to data out delayed by 20 clocks
// - chip select rise copies shift register into control word
// - mode 3: idle high, sample on rise, change after fall
`ifndef MDSP_DEFS_VH
`define MDSP_DEFS_VH

// ----------------------------------------
// serial word
// ----------------------------------------
`define MDSP_WORD_W       20
`define MDSP_WORD_RST     20'h00000

// ----------------------------------------
// status bit positions in the response word
// ----------------------------------------
`define MDSP_ST_SHORT_BIT 3
`define MDSP_ST_OT_BIT    1
`define MDSP_ST_LOAD_BIT  0

// ----------------------------------------
// short protection
// ----------------------------------------
`define MDSP_SC_W         2
`define MDSP_SC_LIMIT     2'h3
`define MDSP_SC_RST       2'h0

// ----------------------------------------
// pin filter: index 0 enable_n, 1 sdi, 2 sck, 3 chip_select_n
// ----------------------------------------
`define MDSP_PIN_N        4
`define MDSP_PIN_ENN      0
`define MDSP_PIN_SDI      1
`define MDSP_PIN_SCK      2
`define MDSP_PIN_CSN      3
`define MDSP_PIN_RST      4'hd

`endif

/* rtl/mdsp_top.v */
`timescale 1ns/100ps
`include "mdsp_defs.vh"

// ----------------------------------------
// pin sampler and glitch filter, one pin
// ----------------------------------------
module mdsp_pin_filt #(
  parameter [0:0] IDLE = 1'b0
) (
  input  wire clk,
  input  wire rst,
  input  wire pin,
  output reg  level_q,
  output reg  prev_q
);

  reg meta_q;
  reg sync_q;
  reg dly_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // two agreeing samples
  // a one-cycle spike never reaches the filtered level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dly_q   <= IDLE;
      level_q <= IDLE;
      prev_q  <= IDLE;
    end else begin
      dly_q  <= sync_q;
      prev_q <= level_q;
      if (sync_q == dly_q) begin
        level_q <= dly_q;
      end
    end
  end

endmodule // mdsp_pin_filt

module mdsp_top #(
  parameter WORD_W = `MDSP_WORD_W
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              sck,
  input  wire              sdi,
  input  wire              chip_select_n,
  input  wire              driver_enable_n,
  input  wire              short_detect,
  input  wire              phase_polarity,
  input  wire              overtemp_shutdown,
  input  wire              load_at_threshold,
  output reg               sdo,
  output reg               sdo_oe_n,
  output reg  [WORD_W-1:0] ctrl_word,
  output reg               ctrl_strobe,
  output reg               chopper_end,
  output reg               driver_shutdown,
  output reg               driver_enabled,
  output reg               short_ground_flag,
  output reg               overtemp_flag,
  output reg               load_threshold_flag,
  output reg               load_threshold_pin
);

  // ----------------------------------------
  // pin synchroniser and glitch filter
  // ----------------------------------------
  wire [`MDSP_PIN_N-1:0] pin_raw;
  wire [`MDSP_PIN_N-1:0] pin_filt_q;
  wire [`MDSP_PIN_N-1:0] pin_prev_q;

  // idle levels keep the edge detectors quiet after reset
  localparam [`MDSP_PIN_N-1:0] PIN_IDLE = `MDSP_PIN_RST;

  assign pin_raw[`MDSP_PIN_ENN] = driver_enable_n;
  assign pin_raw[`MDSP_PIN_SDI] = sdi;
  assign pin_raw[`MDSP_PIN_SCK] = sck;
  assign pin_raw[`MDSP_PIN_CSN] = chip_select_n;

  // one sampler and filter per pin
  mdsp_pin_filt #(
    .IDLE    (PIN_IDLE[`MDSP_PIN_ENN])
  ) u_filt_enn (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_raw[`MDSP_PIN_ENN]),
    .level_q (pin_filt_q[`MDSP_PIN_ENN]),
    .prev_q  (pin_prev_q[`MDSP_PIN_ENN])
  );

  mdsp_pin_filt #(
    .IDLE    (PIN_IDLE[`MDSP_PIN_SDI])
  ) u_filt_sdi (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_raw[`MDSP_PIN_SDI]),
    .level_q (pin_filt_q[`MDSP_PIN_SDI]),
    .prev_q  (pin_prev_q[`MDSP_PIN_SDI])
  );

  mdsp_pin_filt #(
    .IDLE    (PIN_IDLE[`MDSP_PIN_SCK])
  ) u_filt_sck (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_raw[`MDSP_PIN_SCK]),
    .level_q (pin_filt_q[`MDSP_PIN_SCK]),
    .prev_q  (pin_prev_q[`MDSP_PIN_SCK])
  );

  mdsp_pin_filt #(
    .IDLE    (PIN_IDLE[`MDSP_PIN_CSN])
  ) u_filt_csn (
    .clk     (clk),
    .rst     (rst),
    .pin     (pin_raw[`MDSP_PIN_CSN]),
    .level_q (pin_filt_q[`MDSP_PIN_CSN]),
    .prev_q  (pin_prev_q[`MDSP_PIN_CSN])
  );

  // ----------------------------------------
  // filtered levels and edges
  // ----------------------------------------
  wire enn_f;
  wire sdi_f;
  wire sck_f;
  wire csn_f;
  wire sck_rise;
  wire sck_fall;
  wire csn_fall;
  wire csn_rise;

  assign enn_f    = pin_filt_q[`MDSP_PIN_ENN];
  assign sdi_f    = pin_filt_q[`MDSP_PIN_SDI];
  assign sck_f    = pin_filt_q[`MDSP_PIN_SCK];
  assign csn_f    = pin_filt_q[`MDSP_PIN_CSN];
  assign sck_rise = sck_f & ~pin_prev_q[`MDSP_PIN_SCK];
  assign sck_fall = ~sck_f & pin_prev_q[`MDSP_PIN_SCK];
  assign csn_fall = ~csn_f & pin_prev_q[`MDSP_PIN_CSN];
  assign csn_rise = csn_f & ~pin_prev_q[`MDSP_PIN_CSN];

  // ----------------------------------------
  // short-event counter and shutdown
  // ----------------------------------------
  reg [`MDSP_SC_W-1:0] short_cnt_q;
  reg [`MDSP_SC_W-1:0] short_cnt_d;
  reg                  short_off_q;
  reg                  short_off_d;
  reg                  phase_prev_q;
  wire                 phase_flip;
  wire                 short_clear;

  assign phase_flip  = phase_polarity ^ phase_prev_q;
  // clearing happens while the driver is held disabled
  assign short_clear = enn_f;

  // count up and down
  // both events in one cycle cancel out
  always @* begin
    short_cnt_d = short_cnt_q;
    if (short_clear) begin
      short_cnt_d = `MDSP_SC_RST;
    end else if (short_detect && !phase_flip) begin
      if (short_cnt_q != `MDSP_SC_LIMIT) begin
        short_cnt_d = short_cnt_q + 2'h1;
      end
    end else if (phase_flip && !short_detect) begin
      if (short_cnt_q != `MDSP_SC_RST) begin
        short_cnt_d = short_cnt_q - 2'h1;
      end
    end
  end

  // latched shutdown
  // set wins over the clear from disabling
  always @* begin
    short_off_d = short_off_q & ~short_clear;
    if (short_cnt_q == `MDSP_SC_LIMIT) begin
      short_off_d = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      short_cnt_q  <= `MDSP_SC_RST;
      short_off_q  <= 1'b0;
      phase_prev_q <= 1'b0;
    end else begin
      short_cnt_q  <= short_cnt_d;
      short_off_q  <= short_off_d;
      phase_prev_q <= phase_polarity;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      chopper_end         <= 1'b0;
      short_ground_flag   <= 1'b0;
      overtemp_flag       <= 1'b0;
      load_threshold_flag <= 1'b0;
      load_threshold_pin  <= 1'b0;
      driver_shutdown     <= 1'b0;
      driver_enabled      <= 1'b0;
    end else begin
      chopper_end         <= short_detect;
      short_ground_flag   <= short_off_q;
      overtemp_flag       <= overtemp_shutdown;
      load_threshold_flag <= load_at_threshold;
      load_threshold_pin  <= load_at_threshold;
      driver_shutdown     <= short_off_q | overtemp_shutdown;
      driver_enabled      <= ~enn_f & ~short_off_q & ~overtemp_shutdown;
    end
  end

  // ----------------------------------------
  // response word
  // ----------------------------------------
  reg [WORD_W-1:0] resp_word;

  // status in low bits
  // upper readback fields are not carried by this block
  always @* begin
    resp_word = {WORD_W{1'b0}};
    resp_word[`MDSP_ST_SHORT_BIT] = short_ground_flag;
    resp_word[`MDSP_ST_OT_BIT]    = overtemp_flag;
    resp_word[`MDSP_ST_LOAD_BIT]  = load_threshold_flag;
  end

  // ----------------------------------------
  // serial shift register
  // ----------------------------------------
  reg [WORD_W-1:0] shift_q;
  reg [WORD_W-1:0] shift_d;
  reg              sdo_d;
  reg              sdo_oe_n_d;
  reg [WORD_W-1:0] ctrl_word_d;
  reg              ctrl_strobe_d;

  always @* begin
    shift_d       = shift_q;
    sdo_d         = sdo;
    sdo_oe_n_d    = sdo_oe_n;
    ctrl_word_d   = ctrl_word;
    ctrl_strobe_d = 1'b0;
    if (csn_fall) begin
      shift_d    = resp_word;
      sdo_d      = resp_word[WORD_W-1];
      sdo_oe_n_d = 1'b0;
    end else if (!csn_f) begin
      if (sck_rise) begin
        shift_d = {shift_q[WORD_W-2:0], sdi_f};
      end
      if (sck_fall) begin
        sdo_d = shift_q[WORD_W-1];
      end
    end
    if (csn_rise) begin
      // latch on deselect
      // only the last word shifted in is kept when chained
      ctrl_word_d   = shift_q;
      ctrl_strobe_d = 1'b1;
      sdo_oe_n_d    = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q     <= `MDSP_WORD_RST;
      sdo         <= 1'b0;
      sdo_oe_n    <= 1'b1;
      ctrl_word   <= `MDSP_WORD_RST;
      ctrl_strobe <= 1'b0;
    end else begin
      shift_q     <= shift_d;
      sdo         <= sdo_d;
      sdo_oe_n    <= sdo_oe_n_d;
      ctrl_word   <= ctrl_word_d;
      ctrl_strobe <= ctrl_strobe_d;
    end
  end

endmodule // mdsp_top

/* testbench/mdsp_chk.sv */
`timescale 1ns/100ps
module mdsp_chk (
  input wire clk,
  input wire rst,
  input wire chip_select_n,
  input wire short_detect,
  input wire overtemp_shutdown,
  input wire load_at_threshold,
  input wire sdo_oe_n,
  input wire ctrl_strobe,
  input wire chopper_end,
  input wire driver_shutdown,
  input wire driver_enabled,
  input wire short_ground_flag,
  input wire overtemp_flag,
  input wire load_threshold_flag,
  input wire load_threshold_pin
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence csn_frame;
    sdo_oe_n && $fell(chip_select_n) ##1 !chip_select_n [*3];
  endsequence
  sequence csn_glitch;
    sdo_oe_n && $fell(chip_select_n) ##1 $rose(chip_select_n);
  endsequence
  a_chop_end:
    assert property (##1 chopper_end == $past(short_detect))
    else $error("chopper end not tied to short");
  a_flag_set:
    assert property ($rose(short_ground_flag) |-> $past(short_detect, 3))
    else $error("short flag rose without short");
  a_shut_cause:
    assert property (short_ground_flag |-> driver_shutdown && !driver_enabled)
    else $error("short flag without shutdown");
  a_ot_flag:
    assert property (##1 overtemp_flag == $past(overtemp_shutdown))
    else $error("overtemp flag wrong");
  a_load_flag:
    assert property (##1 load_threshold_flag == $past(load_at_threshold)
      && load_threshold_pin == load_threshold_flag)
    else $error("load flag or pin wrong");
  a_strobe_one:
    assert property (ctrl_strobe |=> !ctrl_strobe)
    else $error("latch strobe longer than one cycle");
  a_oe_start:
    assert property (csn_frame |-> ##[0:2] !sdo_oe_n)
    else $error("sdo not driven in frame");
  a_glitch_drop:
    assert property (csn_glitch |=> sdo_oe_n [*5])
    else $error("select glitch started a frame");
endmodule // mdsp_chk
bind mdsp_top mdsp_chk chk (.clk, .rst, .chip_select_n, .short_detect,
  .overtemp_shutdown, .load_at_threshold, .sdo_oe_n, .ctrl_strobe,
  .chopper_end, .driver_shutdown, .driver_enabled, .short_ground_flag,
  .overtemp_flag, .load_threshold_flag, .load_threshold_pin);

/* testbench/mdsp_spi_master.sv */
`timescale 1ns/100ps
module mdsp_spi_master (
  output logic sck,
  output logic sdi,
  output logic chip_select_n,
  input  wire  sdo
);
  // ----------------------------------------
  // serial master
  // ----------------------------------------
  // clock idles high
  initial begin
    sck = 1'b1;
    sdi = 1'b0;
    chip_select_n = 1'b1;
  end
  task automatic xfer(input logic [39:0] tx, input int n,
                      output logic [39:0] rx);
    rx = '0;
    #7 chip_select_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      // change on fall, device samples on rise
      sck = 1'b0;
      sdi = tx[i];
      #160 sck = 1'b1;
      // sdo moves 5 clk after the fall, so take it late
      #120 rx = {rx[38:0], sdo};
      #40;
    end
    #200 chip_select_n = 1'b1;
    sdi = ~sdi;
  endtask
  task automatic glitch();
    #7 chip_select_n = 1'b0;
    #40 chip_select_n = 1'b1;
  endtask
endmodule // mdsp_spi_master

/* testbench/mdsp_top_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module mdsp_top_bench;
  typedef struct { logic ot; logic ld; logic [39:0] tx; int n; } mdsp_row_t;
  logic        clk, rst, sck, sdi, chip_select_n, driver_enable_n;
  logic        short_detect, phase_polarity, overtemp_shutdown;
  logic        load_at_threshold;
  wire         sdo, sdo_oe_n, ctrl_strobe, chopper_end, driver_shutdown;
  wire         driver_enabled, short_ground_flag, overtemp_flag;
  wire         load_threshold_flag, load_threshold_pin;
  wire  [19:0] ctrl_word;
  logic [39:0] rx;
  int          err_count = 0;
  int          checks = 0;
  mdsp_row_t   rows [4] = '{'{1'b0, 1'b0, 40'h5a3c1, 20},
    '{1'b1, 1'b0, 40'hfffff, 20}, '{1'b0, 1'b1, 40'hf0f0f12345, 40},
    '{1'b1, 1'b1, 40'h3c96e00001, 40}};
  mdsp_top dut (.clk, .rst, .sck, .sdi, .chip_select_n, .driver_enable_n,
    .short_detect, .phase_polarity, .overtemp_shutdown, .load_at_threshold,
    .sdo, .sdo_oe_n, .ctrl_word, .ctrl_strobe, .chopper_end,
    .driver_shutdown, .driver_enabled, .short_ground_flag, .overtemp_flag,
    .load_threshold_flag, .load_threshold_pin);
  mdsp_spi_master m (.sck, .sdi, .chip_select_n, .sdo);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic stop_test();
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic run(input logic [39:0] tx, input int n, input logic [3:0] st);
    int k;
    m.xfer(tx, n, rx);
    for (k = 0; k < 20 && ctrl_strobe !== 1'b1; k++) @(negedge clk);
    if (k == 20) begin
      err_count++;
      stop_test();
    end
    `CHK("resp", {16'h0, st}, rx >> (n - 20))
    `CHK("ctrl", tx[19:0], ctrl_word)
    if (n == 40) `CHK("daisy", tx[39:20], rx[19:0])
  endtask
  task automatic pulse_short();
    @(posedge clk) short_detect <= 1'b1;
    @(posedge clk) short_detect <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    driver_enable_n = 1'b1;
    short_detect = 1'b0;
    phase_polarity = 1'b0;
    overtemp_shutdown = 1'b0;
    load_at_threshold = 1'b0;
    tick(5);
    rst <= 1'b0;
    tick(2);
    @(negedge clk);
    `CHK("oe_rst", 1'b1, sdo_oe_n)
    `CHK("ctrl_rst", 20'h0, ctrl_word)
    foreach (rows[i]) begin
      @(posedge clk) overtemp_shutdown <= rows[i].ot;
      load_at_threshold <= rows[i].ld;
      tick(2);
      run(rows[i].tx, rows[i].n, {2'b00, rows[i].ot, rows[i].ld});
      `CHK("ld_pin", rows[i].ld, load_threshold_pin)
      `CHK("ot_flag", rows[i].ot, overtemp_flag)
    end
    @(posedge clk) overtemp_shutdown <= 1'b0;
    load_at_threshold <= 1'b0;
    driver_enable_n <= 1'b0;
    tick(8);
    pulse_short();
    pulse_short();
    @(posedge clk) phase_polarity <= 1'b1;
    pulse_short();
    tick(4);
    @(negedge clk);
    `CHK("no_trip", 1'b0, short_ground_flag)
    pulse_short();
    tick(3);
    @(negedge clk);
    `CHK("trip", 1'b1, short_ground_flag)
    `CHK("enabled", 1'b0, driver_enabled)
    run(40'h0, 20, 4'h8);
    m.glitch();
    tick(8);
    @(negedge clk);
    `CHK("glitch", 1'b1, sdo_oe_n)
    @(posedge clk) driver_enable_n <= 1'b1;
    tick(8);
    @(negedge clk);
    `CHK("clear", 1'b0, short_ground_flag)
    @(posedge clk) driver_enable_n <= 1'b0;
    tick(8);
    @(negedge clk);
    `CHK("reenable", 1'b1, driver_enabled)
    stop_test();
  end
endmodule // mdsp_top_bench
